/* shared/axis_regs.svh */
/*
 Register select codes, field positions and reset values of the axis block.
 Assumes inclusion by bare name from the package and the design files.
*/
`ifndef AXIS_REGS_SVH
`define AXIS_REGS_SVH
`define SEL_SPEED_MON 4'h6
`define SEL_PORT_LEVEL 4'hb
`define SEL_PORT_DIR 4'hc
`define PORT_WIDTH 6
`define PORT_LEVEL_RST 6'h00
`define PORT_DIR_RST 6'h00
`define SPEED_RST 16'h0000
`define CMODE_ORIGIN_BIT 0
`define CMODE_FEED_BIT 2
`define CMODE_DIR_BIT 3
`define COMPAT_NATIVE 2'h0
`endif

/* shared/axis_pkg.sv */
/*
 Types shared by the axis mode and common port block.
 Assumes the constants header is on the include path.
*/
`include "axis_regs.svh"
package axis_pkg;
	typedef enum logic [2:0] {
		MODE_CONT = 3'b000,
		MODE_ORIGIN = 3'b001,
		MODE_ORIGIN_LIM = 3'b010,
		MODE_POSITION = 3'b011,
		MODE_TIMER = 3'b100
	} op_mode_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] sel;
		logic [7:0] wdata;
		logic serial_if;
		logic [1:0] compat;
	} host_req_t;
endpackage

/* rtl/pin_sync.sv */
/*
 Two flip-flop synchroniser for a group of pins.
 Assumes the pins are asynchronous to mclk.
*/
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 6
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule

/* rtl/axis_mode_ports.sv */
/*
 Operation mode decode, continuous run, speed monitor and common ports.
 Assumes the host interface decoder supplies one-cycle wr/rd strobes
 with a select code, and a speed profile engine supplies the pulse
 tick and present speed step.
*/
// What this block does
// - The speed monitor reads zero whenever the axis is stopped.
// - Monitor value times the speed magnification gives the pulse rate.
// - Level bit n drives pin n; reads give pin levels, bits 7:6 zero.
// - Parallel host access: port registers ignore writes and read 00h.
// - One level and one direction register per chip, axis ignored.
// - Native codes 1011b and 1100b select level and direction registers.
// - Direction bit n: 0 makes pin n an output, 1 an input; 7:6 read 0.
// - Exactly five modes: continuous, positioning, origin return, origin return with limit, timer.
// - Mode is decoded from four bits; all four zero selects continuous.
// - In continuous mode a started axis runs until a stop command.
// - Control bit 3 selects the direction, 0 plus and 1 minus.
// - The down-counter decrements from its start value per pulse.
// - Pulse-suppress at 1 withholds output pulses; operation goes on.
// - The position counter counts every pulse at count-stop 0, none at 1.
// - The speed monitor is a read-only 16-bit value in speed-step units.
`timescale 1ns/1ps
module axis_mode_ports
	import axis_pkg::*;
#(
	parameter int SPEED_W = 16,
	parameter int CNT_W = 24
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire host_req_t host,
	input wire logic [7:0] control_mode,
	input wire logic pulse_suppress_bit,
	input wire logic count_stop_bit,
	input wire logic start_cmd,
	input wire logic stop_cmd,
	input wire logic done_evt,
	input wire logic pulse_tick,
	input wire logic [SPEED_W-1:0] profile_speed,
	input wire logic [CNT_W-1:0] feed_load,
	input wire logic feed_load_wr,
	input wire logic [5:0] common_pins_in,
	output logic [5:0] common_pins_out,
	output logic [5:0] common_pins_oe,
	output logic [7:0] read_buffer,
	output logic [15:0] current_speed_monitor,
	output logic pulse_out,
	output logic direction_out,
	output logic running,
	output op_mode_t op_mode,
	output logic [CNT_W-1:0] position_counter,
	output logic [CNT_W-1:0] feed_amount_counter
);
	logic [5:0] level_reg;
	logic [5:0] dir_reg;
	logic [5:0] pins_sync;
	logic running_next;
	logic [CNT_W-1:0] pos_next;
	logic [CNT_W-1:0] feed_next;
	op_mode_t mode_next;

	pin_sync #(.W(`PORT_WIDTH)) u_sync (
		.mclk(mclk),
		.rstn(rstn),
		.d(common_pins_in),
		.q(pins_sync)
	);

	// Port registers are chip-wide: no axis field takes part in the decode
	wire native = host.compat == `COMPAT_NATIVE;
	wire port_ok = native && host.serial_if;
	wire wr_level = host.wr && port_ok && host.sel == `SEL_PORT_LEVEL;
	wire wr_dir = host.wr && port_ok && host.sel == `SEL_PORT_DIR;
	// Input pins show the synchronised pin, output pins their stored level
	wire [5:0] pin_view = (dir_reg & pins_sync) | (~dir_reg & level_reg);
	wire [7:0] rd_level = port_ok ? {2'b00, pin_view} : 8'h00;
	wire [7:0] rd_dir = port_ok ? {2'b00, dir_reg} : 8'h00;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			level_reg <= `PORT_LEVEL_RST;
			dir_reg <= `PORT_DIR_RST;
		end else begin
			if (wr_level)
				level_reg <= host.wdata[5:0];
			if (wr_dir)
				dir_reg <= host.wdata[5:0];
		end
	end

	// Mode table: count-stop, suppress, origin bit, feed-limit bit
	wire cm0 = control_mode[`CMODE_ORIGIN_BIT];
	wire cm2 = control_mode[`CMODE_FEED_BIT];
	always_comb begin
		mode_next = MODE_CONT;
		unique case ({count_stop_bit, pulse_suppress_bit, cm0, cm2})
			4'b0010: mode_next = MODE_ORIGIN;
			4'b0011: mode_next = MODE_ORIGIN_LIM;
			4'b0001: mode_next = MODE_POSITION;
			4'b1101: mode_next = MODE_TIMER;
			default: mode_next = MODE_CONT;
		endcase
	end

	// Continuous mode ends only on stop; other modes may also end on done
	always_comb begin
		running_next = running;
		if (start_cmd)
			running_next = 1'b1;
		if (stop_cmd || (done_evt && mode_next != MODE_CONT))
			running_next = 1'b0;
	end

	wire step = running && pulse_tick;
	wire dir_minus = control_mode[`CMODE_DIR_BIT];
	always_comb begin
		pos_next = position_counter;
		if (step && !count_stop_bit)
			pos_next = dir_minus ? position_counter - 1'b1
				: position_counter + 1'b1;
		feed_next = feed_amount_counter;
		if (feed_load_wr)
			feed_next = feed_load;
		else if (step)
			feed_next = feed_amount_counter - 1'b1;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			running <= 1'b0;
			op_mode <= MODE_CONT;
			position_counter <= '0;
			feed_amount_counter <= '0;
			direction_out <= 1'b0;
		end else begin
			running <= running_next;
			op_mode <= mode_next;
			position_counter <= pos_next;
			feed_amount_counter <= feed_next;
			direction_out <= dir_minus;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pulse_out <= 1'b0;
			current_speed_monitor <= `SPEED_RST;
			common_pins_out <= '0;
			common_pins_oe <= '0;
			read_buffer <= 8'h00;
		end else begin
			pulse_out <= step && !pulse_suppress_bit;
			// Speed in step units; rate = value * magnification
			// Follows running_next so monitor and running fall together
			current_speed_monitor <= running_next ? profile_speed[15:0]
				: `SPEED_RST;
			common_pins_out <= level_reg & ~dir_reg;
			common_pins_oe <= ~dir_reg;
			if (host.rd)
				read_buffer <= host.sel == `SEL_PORT_LEVEL ? rd_level
					: host.sel == `SEL_PORT_DIR ? rd_dir
					: host.sel == `SEL_SPEED_MON && native
					? current_speed_monitor[7:0] : 8'h00;
		end
	end

	property p_parallel_ignored;
		@(posedge mclk) disable iff (!rstn)
		host.wr && !host.serial_if |=> $stable(level_reg) && $stable(dir_reg);
	endproperty
	a_parallel_ignored: assert property (p_parallel_ignored)
		else $error("port register changed on parallel write");

	property p_level_write;
		@(posedge mclk) disable iff (!rstn)
		wr_level |=> level_reg == $past(host.wdata[5:0]);
	endproperty
	a_level_write: assert property (p_level_write)
		else $error("level register not updated");

	property p_input_undriven;
		@(posedge mclk) disable iff (!rstn)
		wr_dir |=> ##1 common_pins_oe == ~$past(host.wdata[5:0], 2);
	endproperty
	a_input_undriven: assert property (p_input_undriven)
		else $error("input pin driven");

	property p_dir_read;
		@(posedge mclk) disable iff (!rstn)
		host.rd && host.sel == `SEL_PORT_DIR |=> read_buffer[7:6] == 2'b00;
	endproperty
	a_dir_read: assert property (p_dir_read)
		else $error("direction read upper bits set");

	property p_stopped_zero;
		@(posedge mclk) disable iff (!rstn)
		!running |-> current_speed_monitor == 16'h0000;
	endproperty
	a_stopped_zero: assert property (p_stopped_zero)
		else $error("speed monitor nonzero while stopped");

	property p_cont_runs;
		@(posedge mclk) disable iff (!rstn)
		running && op_mode == MODE_CONT && !stop_cmd && !start_cmd
			&& mode_next == MODE_CONT |=> running;
	endproperty
	a_cont_runs: assert property (p_cont_runs)
		else $error("continuous run ended without stop");

	property p_suppress;
		@(posedge mclk) disable iff (!rstn)
		pulse_suppress_bit |=> !pulse_out;
	endproperty
	a_suppress: assert property (p_suppress)
		else $error("pulse output while suppressed");

	property p_count;
		@(posedge mclk) disable iff (!rstn)
		step && !count_stop_bit && !dir_minus
			|=> position_counter == $past(position_counter) + 1'b1;
	endproperty
	a_count: assert property (p_count)
		else $error("position counter missed a pulse");

	property p_feed_dec;
		@(posedge mclk) disable iff (!rstn)
		step && !feed_load_wr
			|=> feed_amount_counter == $past(feed_amount_counter) - 1'b1;
	endproperty
	a_feed_dec: assert property (p_feed_dec)
		else $error("down counter did not decrement");

	property p_compat_ignored;
		@(posedge mclk) disable iff (!rstn)
		host.wr && host.compat != `COMPAT_NATIVE
			|=> $stable(level_reg) && $stable(dir_reg);
	endproperty
	a_compat_ignored: assert property (p_compat_ignored)
		else $error("port register changed outside native mode");

	property p_parallel_read;
		@(posedge mclk) disable iff (!rstn)
		host.rd && !host.serial_if
			&& (host.sel == `SEL_PORT_LEVEL || host.sel == `SEL_PORT_DIR)
			|=> read_buffer == 8'h00;
	endproperty
	a_parallel_read: assert property (p_parallel_read)
		else $error("port register read over parallel access");

	property p_dir_write;
		@(posedge mclk) disable iff (!rstn)
		wr_dir |=> dir_reg == $past(host.wdata[5:0]);
	endproperty
	a_dir_write: assert property (p_dir_write)
		else $error("direction register not updated");

	property p_idle_hold;
		@(posedge mclk) disable iff (!rstn)
		!running |=> !pulse_out && $stable(position_counter);
	endproperty
	a_idle_hold: assert property (p_idle_hold)
		else $error("pulse or count while stopped");

	property p_count_down;
		@(posedge mclk) disable iff (!rstn)
		step && !count_stop_bit && dir_minus
			|=> position_counter == $past(position_counter) - 1'b1;
	endproperty
	a_count_down: assert property (p_count_down)
		else $error("position counter did not count down");
endmodule

/* test/host_model.sv */
/*
 Host processor model issuing one-cycle register requests.
 Assumes the block takes requests on the rising edge of mclk.
*/
`timescale 1ns/1ps
module host_model
	import axis_pkg::*;
(
	input wire logic mclk,
	input wire logic [7:0] read_buffer,
	output host_req_t host
);
	initial host = '0;
	// Data lines show a fresh pattern once a request is released
	task automatic acc(input logic w, ser, input logic [1:0] cm,
		input logic [3:0] s, input logic [7:0] d, output logic [7:0] q);
		@(negedge mclk);
		host = '{wr: w, rd: !w, sel: s, wdata: d, serial_if: ser, compat: cm};
		@(negedge mclk);
		host.wr = 1'b0;
		host.rd = 1'b0;
		host.wdata = ~d;
		q = read_buffer;
	endtask
endmodule

/* test/testbench.sv */
/*
 Self-checking bench for the mode and common port block.
 Assumes the host model and a pin resolver stand at the far side.
*/
`timescale 1ns/1ps
module testbench;
	import axis_pkg::*;
	logic mclk, rstn, cs, ps, st, sp, dn, tk, fw;
	logic [7:0] cmode, q;
	logic [5:0] ext, po, oe;
	logic [7:0] rb;
	logic [15:0] mon;
	logic pls, dir, run;
	logic [23:0] pos, fd;
	op_mode_t om;
	host_req_t host;
	int failures = 0;
	int compares = 0;
	logic [22:0] rows[8] = '{{1'b1, 2'h0, 4'hc, 8'hc3, 8'h03},
		{1'b1, 2'h0, 4'hb, 8'hff, 8'h3e}, {1'b0, 2'h0, 4'hb, 8'h00, 8'h00},
		{1'b1, 2'h1, 4'hb, 8'h00, 8'h00}, {1'b1, 2'h2, 4'hc, 8'h3f, 8'h00},
		{1'b1, 2'h0, 4'h6, 8'hff, 8'h00}, {1'b1, 2'h0, 4'h0, 8'h55, 8'h00},
		{1'b1, 2'h0, 4'hc, 8'h00, 8'h00}};
	logic [3:0] mb[5] = '{4'b0000, 4'b0010, 4'b0011, 4'b0001, 4'b1101};
	op_mode_t me[5] = '{MODE_CONT, MODE_ORIGIN, MODE_ORIGIN_LIM,
		MODE_POSITION, MODE_TIMER};
	wire [5:0] pins = (oe & po) | (~oe & ext);
	host_model host_model_i (.mclk(mclk), .read_buffer(rb), .host(host));
	axis_mode_ports axis_mode_ports_i (.mclk(mclk), .rstn(rstn),
		.host(host), .control_mode(cmode), .pulse_suppress_bit(ps),
		.count_stop_bit(cs), .start_cmd(st), .stop_cmd(sp), .done_evt(dn),
		.pulse_tick(tk), .profile_speed(16'h0123), .feed_load(24'h000010),
		.feed_load_wr(fw), .common_pins_in(pins), .common_pins_out(po),
		.common_pins_oe(oe), .read_buffer(rb), .current_speed_monitor(mon),
		.pulse_out(pls), .direction_out(dir), .running(run), .op_mode(om),
		.position_counter(pos), .feed_amount_counter(fd));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic chk(input logic [23:0] g, e);
		compares++;
		if (g !== e) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic conclude();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic tick(input logic ep, input logic [23:0] ep_pos, ep_fd);
		@(negedge mclk);
		tk = 1'b1;
		@(negedge mclk);
		tk = 1'b0;
		chk(pls, ep);
		chk(pos, ep_pos);
		chk(fd, ep_fd);
	endtask
	initial begin
		#100000;
		failures++;
		conclude();
	end
	initial begin
		{rstn, cs, ps, st, sp, dn, tk, fw, cmode} = '0;
		ext = 6'h2a;
		repeat (3) @(negedge mclk);
		rstn = 1'b1;
		@(negedge mclk);
		chk(oe, 6'h3f);
		chk({po, mon}, '0);
		$display("reset test done");
		for (int i = 0; i < 8; i++) begin
			host_model_i.acc(1'b1, rows[i][22], rows[i][21:20], rows[i][19:16],
				rows[i][15:8], q);
			repeat (4) @(negedge mclk);
			host_model_i.acc(1'b0, rows[i][22], rows[i][21:20], rows[i][19:16],
				rows[i][15:8], q);
			chk(q, rows[i][7:0]);
		end
		chk({oe, po}, 12'hfff);
		$display("register test done");
		for (int i = 0; i < 5; i++) begin
			{cs, ps, cmode[0], cmode[2]} = mb[i];
			repeat (2) @(negedge mclk);
			chk(om, me[i]);
		end
		{cs, ps, cmode} = '0;
		fw = 1'b1;
		@(negedge mclk);
		fw = 1'b0;
		st = 1'b1;
		@(negedge mclk);
		st = 1'b0;
		dn = 1'b1;
		@(negedge mclk);
		dn = 1'b0;
		@(negedge mclk);
		chk({run, mon}, 17'h10123);
		tick(1'b1, 24'h1, 24'hf);
		ps = 1'b1;
		tick(1'b0, 24'h2, 24'he);
		{ps, cs} = 2'b01;
		tick(1'b1, 24'h2, 24'hd);
		cs = 1'b0;
		cmode = 8'h08;
		tick(1'b1, 24'h1, 24'hc);
		chk(dir, 1'b1);
		sp = 1'b1;
		@(negedge mclk);
		sp = 1'b0;
		repeat (2) @(negedge mclk);
		chk({run, mon}, 17'h0);
		tick(1'b0, 24'h1, 24'hc);
		$display("motion test done");
		rstn = 1'b0;
		@(negedge mclk);
		chk(pos, '0);
		chk({run, oe, po, mon[7:0]}, '0);
		rstn = 1'b1;
		@(negedge mclk);
		chk({oe, po}, 12'hfc0);
		chk(mon, '0);
		host_model_i.acc(1'b0, 1'b1, 2'h0, 4'hb, 8'h00, q);
		chk(q, 8'h00);
		$display("second reset test done");
		conclude();
	end
endmodule
